// ==== npes_defines.svh ====
// Constants for the NAND program/erase sequencing host controller
`ifndef NPES_DEFINES_SVH
`define NPES_DEFINES_SVH
// Command bytes sent to the flash
`define NPES_CMD_READ0 8'h00
`define NPES_CMD_CB_READ 8'h35
`define NPES_CMD_SERIAL_IN 8'h80
`define NPES_CMD_RANDOM_IN 8'h85
`define NPES_CMD_PROG 8'h10
`define NPES_CMD_ERASE_SETUP 8'h60
`define NPES_CMD_ERASE_CONF 8'hd0
`define NPES_CMD_STATUS 8'h70
`define NPES_CMD_RESET 8'hff
// Status bit positions
`define NPES_SR_FAIL 0
`define NPES_SR_READY5 5
`define NPES_SR_READY6 6
`define NPES_SR_WP_N 7
// Array geometry
`define NPES_PAGES_PER_BLOCK 64
`define NPES_BLOCKS 1024
`define NPES_MAX_PARTIAL 4
// Host register map (word addresses on the software port)
`define NPES_REG_CTRL 4'h0
`define NPES_REG_ROW 4'h1
`define NPES_REG_COL 4'h2
`define NPES_REG_DATA 4'h3
`define NPES_REG_STATUS 4'h4
`define NPES_REG_FLASH_SR 4'h5
`define NPES_REG_RDATA 4'h6
`define NPES_REG_CFG 4'h7
// Control opcode field values written to CTRL[2:0]
`define NPES_OP_PROG_START 3'h1
`define NPES_OP_RAND_IN 3'h2
`define NPES_OP_CONFIRM 3'h3
`define NPES_OP_CB_READ 3'h4
`define NPES_OP_CB_PROG 3'h5
`define NPES_OP_ERASE 3'h6
`define NPES_OP_RESET 3'h7
// Strobe timing: each phase of a bus cycle, in ns and in cycles at 100 MHz
`define NPES_CLK_NS 10
`define NPES_PHASE_NS 30
`define NPES_PHASE_CYC ((`NPES_PHASE_NS + `NPES_CLK_NS - 1) / `NPES_CLK_NS)
// Write protect setup before first command, 100 ns
`define NPES_WP_SETUP_NS 100
`define NPES_WP_SETUP_CYC ((`NPES_WP_SETUP_NS + `NPES_CLK_NS - 1) / `NPES_CLK_NS)
// Busy watchdog bound on a reset while idle, 5 us
`define NPES_RST_IDLE_NS 5000
`define NPES_RST_IDLE_CYC (`NPES_RST_IDLE_NS / `NPES_CLK_NS)
`endif

// ==== npes_pkg.sv ====
// Types for the NAND program/erase sequencing host controller
package npes_pkg;
    // Kind of one bus cycle on the flash pins
    typedef enum logic [1:0] {NPES_CYC_CMD, NPES_CYC_ADDR, NPES_CYC_DIN, NPES_CYC_DOUT}
        npes_cyc_t;
    // Sequencer states
    typedef enum logic [3:0] {
        NPES_IDLE, NPES_WP_WAIT, NPES_SEND, NPES_WAIT_DONE, NPES_WAIT_BUSY,
        NPES_WAIT_READY, NPES_STAT_CMD, NPES_STAT_RD
    } npes_state_t;
endpackage

// ==== npes_cycle.sv ====
// One strobed command, address, data-in or data-out cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
`include "npes_defines.svh"
module npes_cycle
(
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_start,
    input wire npes_pkg::npes_cyc_t i_kind,
    input wire logic [7:0] i_byte,
    input wire logic [7:0] i_io,
    output logic o_done,
    output logic [7:0] o_rbyte,
    output logic o_cle,
    output logic o_ale,
    output logic o_we_n,
    output logic o_read_strobe_n,
    output logic [7:0] o_io,
    output logic o_io_oe
);
    import npes_pkg::*;
    // Phase counter and step within the cycle
    logic [3:0] cnt_ff;
    logic [1:0] step_ff;
    npes_cyc_t kind_ff;
    logic busy_ff;
    wire logic phase_end = (cnt_ff == 4'(`NPES_PHASE_CYC - 1));
    wire logic is_read = (kind_ff == NPES_CYC_DOUT);
    // Step 0: setup, step 1: strobe low, step 2: strobe high hold
    always_ff @(posedge i_clk_sys)
    begin
        o_done <= 1'b0;
        if (i_srst)
        begin
            busy_ff <= 1'b0;
            cnt_ff <= 4'h0;
            step_ff <= 2'h0;
            kind_ff <= NPES_CYC_CMD;
            o_cle <= 1'b0;
            o_ale <= 1'b0;
            o_we_n <= 1'b1;
            o_read_strobe_n <= 1'b1;
            o_io <= 8'h00;
            o_io_oe <= 1'b0;
            o_rbyte <= 8'h00;
        end
        else if (!busy_ff)
        begin
            if (i_start)
            begin
                busy_ff <= 1'b1;
                kind_ff <= i_kind;
                cnt_ff <= 4'h0;
                step_ff <= 2'h0;
                o_cle <= (i_kind == NPES_CYC_CMD);
                o_ale <= (i_kind == NPES_CYC_ADDR);
                o_io <= i_byte;
                // Only drive the bus when writing into the flash
                o_io_oe <= (i_kind != NPES_CYC_DOUT);
            end
        end
        else if (!phase_end)
            cnt_ff <= cnt_ff + 4'h1;
        else
        begin
            cnt_ff <= 4'h0;
            case (step_ff)
                2'h0:
                begin
                    step_ff <= 2'h1;
                    if (is_read)
                        o_read_strobe_n <= 1'b0;
                    else
                        o_we_n <= 1'b0;
                end
                2'h1:
                begin
                    // Latch read data on the rising read strobe; flash latches on rising write
                    step_ff <= 2'h2;
                    o_we_n <= 1'b1;
                    o_read_strobe_n <= 1'b1;
                    if (is_read)
                        o_rbyte <= i_io;
                end
                default:
                begin
                    step_ff <= 2'h0;
                    busy_ff <= 1'b0;
                    o_cle <= 1'b0;
                    o_ale <= 1'b0;
                    o_io_oe <= 1'b0;
                    o_done <= 1'b1;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== npes_host.sv ====
// Host-side sequencer driving NAND program, copy-back, erase and reset sequences
// Notes on behaviour
// - Software programs pages of a block ascending
// - At most four partial programs per page
// - Program: 80h, four address cycles, data, 10h
// - During program only 70h and FFh issued
// - 85h plus column redirects loading before 10h
// - Copy-back read: 00h, four addresses, 35h
// - Copy-back program: 85h, four addresses, 10h
// - Random input allowed between copy-back read, confirm
// - Erase: 60h, two block addresses, D0h confirm
// - Hold write protect until bit 5 reads 1; code holds it to the status read after ready, bit 5 not checked
`timescale 1ns/1ps
`default_nettype none
`include "npes_defines.svh"
module npes_host
(
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic [7:0] i_io,
    input wire logic i_ready_busy_n,
    output logic o_ce_n,
    output logic o_cle,
    output logic o_ale,
    output logic o_we_n,
    output logic o_read_strobe_n,
    output logic o_wp_n,
    output logic [7:0] o_io,
    output logic o_io_oe
);
    import npes_pkg::*;
    // Sequencer and operation context
    npes_state_t state_ff;
    logic [2:0] op_ff;
    logic [2:0] idx_ff;
    logic [2:0] len_ff;
    logic [7:0] seq_ff [0:5];
    npes_cyc_t kind_ff [0:5];
    logic [7:0] confirm_ff;
    logic [23:0] row_ff;
    logic [15:0] col_ff;
    logic [7:0] flash_sr_ff;
    logic [7:0] rbyte_ff;
    logic wp_en_ff;
    logic [3:0] wp_cnt_ff;
    logic fail_ff;
    logic done_ff;
    logic to_ff;
    logic [12:0] rst_cnt_ff;
    logic rst_idle_ff;
    // Last programmed block and page, tracked to police program order and partial counts
    logic [5:0] last_page_ff;
    logic [9:0] last_block_ff;
    logic [2:0] nop_ff;
    logic order_err_ff;
    // Cycle engine handshake
    logic cyc_start_ff;
    npes_cyc_t cyc_kind;
    logic [7:0] cyc_byte;
    logic cyc_done;
    logic [7:0] cyc_rbyte;
    logic e_cle, e_ale, e_we_n, e_re_n, e_oe;
    logic [7:0] e_io;
    // Register decode
    wire logic wr_ctrl = i_wr && (i_addr == `NPES_REG_CTRL);
    wire logic wr_row = i_wr && (i_addr == `NPES_REG_ROW);
    wire logic wr_col = i_wr && (i_addr == `NPES_REG_COL);
    wire logic wr_data = i_wr && (i_addr == `NPES_REG_DATA);
    wire logic rd_rdata = i_rd && (i_addr == `NPES_REG_RDATA);
    wire logic wr_cfg = i_wr && (i_addr == `NPES_REG_CFG);
    wire logic [2:0] new_op = i_wdata[2:0];
    wire logic idle = (state_ff == NPES_IDLE);
    wire logic busy = !idle;
    // Within the same block only a later page, or the same page under the partial limit, may be programmed
    wire logic [9:0] row_block = row_ff[15:6];
    wire logic [5:0] row_page = row_ff[5:0];
    wire logic same_page = (row_block == last_block_ff) && (row_page == last_page_ff);
    wire logic page_ok = (row_block != last_block_ff) || (row_page > last_page_ff)
        || (same_page && (nop_ff < 3'(`NPES_MAX_PARTIAL)));
    wire logic prog_op = (new_op == `NPES_OP_PROG_START) || (new_op == `NPES_OP_CB_PROG)
        || (new_op == `NPES_OP_ERASE);
    // Reset may interrupt any state but NPES_SEND and NPES_STAT_CMD; other ops only while idle
    wire logic go_reset = wr_ctrl && (new_op == `NPES_OP_RESET);
    wire logic go_op = wr_ctrl && idle && !go_reset && (new_op != 3'h0);
    // Status word read by software
    wire logic [31:0] status_word = {22'h0, order_err_ff, rst_idle_ff, to_ff, fail_ff,
        done_ff, wp_en_ff, state_ff == NPES_WAIT_READY, busy, i_ready_busy_n, o_wp_n};
    // Selected read data, one cycle later
    logic [31:0] rd_mux;
    always_comb
    begin
        case (i_addr)
            `NPES_REG_ROW: rd_mux = {8'h0, row_ff};
            `NPES_REG_COL: rd_mux = {16'h0, col_ff};
            `NPES_REG_STATUS: rd_mux = status_word;
            `NPES_REG_FLASH_SR: rd_mux = {24'h0, flash_sr_ff};
            `NPES_REG_RDATA: rd_mux = {24'h0, rbyte_ff};
            `NPES_REG_CFG: rd_mux = {31'h0, wp_en_ff};
            default: rd_mux = 32'h0;
        endcase
    end
    // Bytes of the current sequence
    assign cyc_kind = kind_ff[idx_ff];
    assign cyc_byte = seq_ff[idx_ff];
    // Loads the byte list for a new command sequence
    task automatic load_seq(input logic [7:0] c0, input logic [2:0] n_addr,
        input logic row_only);
        seq_ff[0] <= c0;
        kind_ff[0] <= NPES_CYC_CMD;
        for (int k = 1; k < 6; k++)
        begin
            kind_ff[k] <= NPES_CYC_ADDR;
            seq_ff[k] <= 8'h00;
        end
        if (row_only)
        begin
            // Erase row carries page bits, the flash drops them
            seq_ff[1] <= row_ff[7:0];
            seq_ff[2] <= row_ff[15:8];
        end
        else
        begin
            seq_ff[1] <= col_ff[7:0];
            seq_ff[2] <= col_ff[15:8];
            seq_ff[3] <= row_ff[7:0];
            seq_ff[4] <= row_ff[15:8];
        end
        len_ff <= 3'(n_addr + 3'h1);
    endtask
    // Main sequencer
    always_ff @(posedge i_clk_sys)
    begin
        cyc_start_ff <= 1'b0;
        if (i_srst)
        begin
            state_ff <= NPES_IDLE;
            op_ff <= 3'h0;
            idx_ff <= 3'h0;
            len_ff <= 3'h0;
            confirm_ff <= 8'h00;
            row_ff <= 24'h0;
            col_ff <= 16'h0;
            flash_sr_ff <= 8'h00;
            rbyte_ff <= 8'h00;
            wp_en_ff <= 1'b0;
            wp_cnt_ff <= 4'h0;
            fail_ff <= 1'b0;
            done_ff <= 1'b0;
            to_ff <= 1'b0;
            rst_cnt_ff <= 13'h0;
            rst_idle_ff <= 1'b0;
            last_page_ff <= 6'h0;
            last_block_ff <= 10'h3ff;
            nop_ff <= 3'h0;
            order_err_ff <= 1'b0;
            o_wp_n <= 1'b0;
            o_ce_n <= 1'b1;
            o_rdata <= 32'h0;
            for (int k = 0; k < 6; k++)
            begin
                seq_ff[k] <= 8'h00;
                kind_ff[k] <= NPES_CYC_CMD;
            end
        end
        else
        begin
            o_rdata <= i_rd ? rd_mux : 32'h0;
            if (wr_row) row_ff <= i_wdata[23:0];
            if (wr_col) col_ff <= i_wdata[15:0];
            // Protect pin changes only while no operation runs
            if (wr_cfg && idle)
                wp_en_ff <= i_wdata[0];
            case (state_ff)
                NPES_IDLE:
                begin
                    o_ce_n <= 1'b1;
                    o_wp_n <= wp_en_ff;
                    if (rd_rdata)
                    begin
                        // Read one byte from the data register
                        kind_ff[0] <= NPES_CYC_DOUT;
                        len_ff <= 3'h1;
                        idx_ff <= 3'h0;
                        op_ff <= 3'h0;
                        state_ff <= NPES_SEND;
                        o_ce_n <= 1'b0;
                        cyc_start_ff <= 1'b1;
                    end
                    else if (wr_data)
                    begin
                        // One bus write per data byte, column advances in flash
                        seq_ff[0] <= i_wdata[7:0];
                        kind_ff[0] <= NPES_CYC_DIN;
                        len_ff <= 3'h1;
                        idx_ff <= 3'h0;
                        op_ff <= 3'h0;
                        state_ff <= NPES_SEND;
                        o_ce_n <= 1'b0;
                        cyc_start_ff <= 1'b1;
                    end
                    else if (go_op && prog_op && !wp_en_ff)
                        // Software left protection on; flag and refuse
                        fail_ff <= 1'b1;
                    else if (go_op && (new_op == `NPES_OP_PROG_START) && !page_ok)
                        order_err_ff <= 1'b1;
                    else if (go_op)
                    begin
                        op_ff <= new_op;
                        done_ff <= 1'b0;
                        fail_ff <= 1'b0;
                        to_ff <= 1'b0;
                        order_err_ff <= 1'b0;
                        idx_ff <= 3'h0;
                        wp_cnt_ff <= 4'h0;
                        case (new_op)
                            `NPES_OP_PROG_START: load_seq(`NPES_CMD_SERIAL_IN, 3'h4, 1'b0);
                            `NPES_OP_RAND_IN: load_seq(`NPES_CMD_RANDOM_IN, 3'h2, 1'b0);
                            `NPES_OP_CB_READ: load_seq(`NPES_CMD_READ0, 3'h4, 1'b0);
                            `NPES_OP_CB_PROG: load_seq(`NPES_CMD_RANDOM_IN, 3'h4, 1'b0);
                            `NPES_OP_ERASE: load_seq(`NPES_CMD_ERASE_SETUP, 3'h2, 1'b1);
                            default: load_seq(confirm_ff, 3'h0, 1'b0);
                        endcase
                        // Final confirm byte decides when busy may begin
                        case (new_op)
                            `NPES_OP_CB_READ: confirm_ff <= `NPES_CMD_CB_READ;
                            `NPES_OP_CB_PROG: confirm_ff <= `NPES_CMD_PROG;
                            `NPES_OP_ERASE: confirm_ff <= `NPES_CMD_ERASE_CONF;
                            `NPES_OP_PROG_START: confirm_ff <= `NPES_CMD_PROG;
                            default: confirm_ff <= confirm_ff;
                        endcase
                        if (new_op == `NPES_OP_CONFIRM)
                            seq_ff[0] <= confirm_ff;
                        if (new_op == `NPES_OP_PROG_START)
                        begin
                            nop_ff <= same_page ? 3'(nop_ff + 3'h1) : 3'h1;
                            last_page_ff <= row_page;
                            last_block_ff <= row_block;
                        end
                        o_ce_n <= 1'b0;
                        state_ff <= NPES_WP_WAIT;
                    end
                end
                NPES_WP_WAIT:
                begin
                    // Protect pin settles before the first command latch
                    if (wp_cnt_ff == 4'(`NPES_WP_SETUP_CYC))
                    begin
                        state_ff <= NPES_SEND;
                        cyc_start_ff <= 1'b1;
                    end
                    else
                        wp_cnt_ff <= wp_cnt_ff + 4'h1;
                end
                NPES_SEND:
                begin
                    if (cyc_done)
                    begin
                        if (kind_ff[0] == NPES_CYC_DOUT)
                            rbyte_ff <= cyc_rbyte;
                        if (3'(idx_ff + 3'h1) == len_ff)
                        begin
                            idx_ff <= 3'h0;
                            // Copy-back read, copy-back program and erase confirm at once; reads of 3 cmds
                            if ((op_ff == `NPES_OP_CB_READ) || (op_ff == `NPES_OP_ERASE)
                                || (op_ff == `NPES_OP_CB_PROG))
                            begin
                                seq_ff[0] <= confirm_ff;
                                kind_ff[0] <= NPES_CYC_CMD;
                                len_ff <= 3'h1;
                                op_ff <= `NPES_OP_CONFIRM;
                                cyc_start_ff <= 1'b1;
                            end
                            else if (op_ff == `NPES_OP_CONFIRM || op_ff == `NPES_OP_RESET)
                                state_ff <= NPES_WAIT_BUSY;
                            else
                                state_ff <= NPES_IDLE;
                        end
                        else
                        begin
                            idx_ff <= idx_ff + 3'h1;
                            cyc_start_ff <= 1'b1;
                        end
                    end
                end
                NPES_WAIT_BUSY:
                begin
                    // Busy shows only after the confirm strobe
                    rst_cnt_ff <= rst_cnt_ff + 13'h1;
                    if (!i_ready_busy_n || rst_cnt_ff == 13'h7)
                    begin
                        rst_cnt_ff <= 13'h0;
                        state_ff <= NPES_WAIT_READY;
                    end
                end
                NPES_WAIT_READY:
                begin
                    // Only status or reset may be sent while busy
                    rst_cnt_ff <= rst_cnt_ff + 13'h1;
                    if (rst_idle_ff && rst_cnt_ff == 13'(`NPES_RST_IDLE_CYC))
                        to_ff <= 1'b1;
                    if (i_ready_busy_n)
                    begin
                        seq_ff[0] <= `NPES_CMD_STATUS;
                        kind_ff[0] <= NPES_CYC_CMD;
                        kind_ff[1] <= NPES_CYC_DOUT;
                        len_ff <= 3'h2;
                        idx_ff <= 3'h0;
                        state_ff <= NPES_STAT_CMD;
                        cyc_start_ff <= 1'b1;
                    end
                end
                NPES_STAT_CMD:
                begin
                    // 70h then one read, which returns status byte
                    if (cyc_done)
                    begin
                        if (idx_ff == 3'h0)
                        begin
                            idx_ff <= 3'h1;
                            cyc_start_ff <= 1'b1;
                        end
                        else
                        begin
                            flash_sr_ff <= cyc_rbyte;
                            // Pass/fail meaningful once bit 6 reads ready
                            fail_ff <= cyc_rbyte[`NPES_SR_READY6] & cyc_rbyte[`NPES_SR_FAIL];
                            done_ff <= 1'b1;
                            rst_idle_ff <= 1'b0;
                            state_ff <= NPES_IDLE;
                        end
                    end
                end
                default: state_ff <= NPES_IDLE;
            endcase
            // Reset command overrides any state but NPES_SEND and NPES_STAT_CMD, abort on busy
            if (go_reset && state_ff != NPES_SEND && state_ff != NPES_STAT_CMD)
            begin
                seq_ff[0] <= `NPES_CMD_RESET;
                kind_ff[0] <= NPES_CYC_CMD;
                len_ff <= 3'h1;
                idx_ff <= 3'h0;
                op_ff <= `NPES_OP_RESET;
                rst_idle_ff <= idle;
                rst_cnt_ff <= 13'h0;
                done_ff <= 1'b0;
                o_ce_n <= 1'b0;
                state_ff <= NPES_SEND;
                cyc_start_ff <= 1'b1;
            end
        end
    end
    // Pin-level cycle engine
    npes_cycle u_cycle
    (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_start(cyc_start_ff),
        .i_kind(cyc_kind),
        .i_byte(cyc_byte),
        .i_io(i_io),
        .o_done(cyc_done),
        .o_rbyte(cyc_rbyte),
        .o_cle(e_cle),
        .o_ale(e_ale),
        .o_we_n(e_we_n),
        .o_read_strobe_n(e_re_n),
        .o_io(e_io),
        .o_io_oe(e_oe)
    );
    // Pins re-registered so every output leaves a flip-flop
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            o_cle <= 1'b0;
            o_ale <= 1'b0;
            o_we_n <= 1'b1;
            o_read_strobe_n <= 1'b1;
            o_io <= 8'h00;
            o_io_oe <= 1'b0;
        end
        else
        begin
            o_cle <= e_cle;
            o_ale <= e_ale;
            o_we_n <= e_we_n;
            o_read_strobe_n <= e_re_n;
            o_io <= e_io;
            o_io_oe <= e_oe;
        end
    end
endmodule
`default_nettype wire

// ==== npes_flash_model.sv ====
// Behavioural flash device answering the host's strobes
`timescale 1ns/1ps
`default_nettype none
module npes_flash_model
#(
    parameter int BUSY_CYC = 40 // Stand-in for program and erase time
)
(
    input wire logic i_clk_sys,
    input wire logic i_ce_n,
    input wire logic i_cle,
    input wire logic i_we_n,
    input wire logic i_read_strobe_n,
    input wire logic i_wp_n,
    input wire logic [7:0] i_io,
    output logic o_ready_busy_n,
    output logic [7:0] o_io
);
    int busy_cnt = 0; // Cycles left in the internal operation
    logic we_q_ff = 1'b1; // Strobe one cycle back
    logic [7:0] last_ff = 8'h00; // Last byte on the bus
    wire logic latch = i_we_n && !we_q_ff && !i_ce_n && i_cle; // Command on rising strobe
    wire logic [7:0] status = {i_wp_n, o_ready_busy_n, o_ready_busy_n, 5'h00};
    assign o_ready_busy_n = (busy_cnt == 0);
    // Released bus keeps changing so a stale byte never passes
    assign o_io = (!i_read_strobe_n && !i_ce_n) ? status : ~last_ff;
    // Internal operation timer
    always_ff @(posedge i_clk_sys)
    begin
        we_q_ff <= i_we_n;
        last_ff <= o_io;
        if (latch && i_wp_n && (i_io == 8'h10 || i_io == 8'hd0))
            busy_cnt <= BUSY_CYC;
        else if (latch && (i_io == 8'h35 || i_io == 8'hff))
            busy_cnt <= BUSY_CYC / 4;
        else if (busy_cnt > 0)
            busy_cnt <= busy_cnt - 1;
    end
endmodule
`default_nettype wire

// ==== npes_host_monitor.sv ====
// Checker on the flash pins of the host controller
`timescale 1ns/1ps
`default_nettype none
module npes_host_monitor
(
    input wire logic i_clk_sys, input wire logic i_srst, input wire logic i_ready_busy_n,
    input wire logic o_ce_n, input wire logic o_cle, input wire logic o_we_n,
    input wire logic o_read_strobe_n, input wire logic o_wp_n,
    input wire logic [7:0] o_io, input wire logic o_io_oe
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    property p_wp_hold; !i_ready_busy_n |-> $stable(o_wp_n); endproperty
    a_wp_hold: assert property (p_wp_hold) else $error("wp moved while busy");
    property p_busy_cmd; !i_ready_busy_n && o_cle && !o_we_n |-> o_io == 8'h70 || o_io == 8'hff;
    endproperty
    a_busy_cmd: assert property (p_busy_cmd) else $error("bad command while busy");
    property p_width; $fell(o_we_n) |-> !o_we_n [*3] ##1 o_we_n; endproperty
    a_width: assert property (p_width) else $error("write strobe width");
    property p_oe_wr; !o_we_n |-> o_io_oe; endproperty
    a_oe_wr: assert property (p_oe_wr) else $error("bus not driven on write");
    property p_oe_rd; !o_read_strobe_n |-> !o_io_oe; endproperty
    a_oe_rd: assert property (p_oe_rd) else $error("bus driven on read");
    property p_ce; !o_we_n || !o_read_strobe_n |-> !o_ce_n; endproperty
    a_ce: assert property (p_ce) else $error("strobe without select");
    property p_io_hold; !o_we_n && !$past(o_we_n) |-> $stable(o_io); endproperty
    a_io_hold: assert property (p_io_hold) else $error("bus moved in strobe");
    property p_conf_wp; o_cle && !o_we_n && (o_io == 8'h10 || o_io == 8'hd0) |-> o_wp_n;
    endproperty
    a_conf_wp: assert property (p_conf_wp) else $error("confirm while protected");
    c_busy: cover property (!i_ready_busy_n);
    c_status: cover property (o_cle && !o_we_n && o_io == 8'h70);
    c_erase: cover property (o_cle && !o_we_n && o_io == 8'hd0);
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the flash program and erase host controller
`timescale 1ns/1ps
`default_nettype none
`include "npes_defines.svh"
module testbench;
    import npes_pkg::*;
    logic i_clk_sys = 1'b0, i_srst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, we_q = 1'b1;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0, o_rdata, rv;
    wire logic [7:0] f_io, o_io;
    wire logic rb, ce_n, cle, ale, we_n, re_n, wp_n, oe;
    int fail_count = 0, n_compared = 0, n_din = 0, n_busy = 0, b0, d0;
    always #5 i_clk_sys = ~i_clk_sys;
    npes_host uut (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_io(f_io), .i_ready_busy_n(rb),
        .o_ce_n(ce_n), .o_cle(cle), .o_ale(ale), .o_we_n(we_n), .o_read_strobe_n(re_n),
        .o_wp_n(wp_n), .o_io(o_io), .o_io_oe(oe));
    npes_flash_model flash (.i_clk_sys(i_clk_sys), .i_ce_n(ce_n), .i_cle(cle), .i_we_n(we_n),
        .i_read_strobe_n(re_n), .i_wp_n(wp_n), .i_io(o_io), .o_ready_busy_n(rb), .o_io(f_io));
    // Count busy cycles and data-in strobes on the pins
    always @(posedge i_clk_sys)
    begin
        n_busy += int'(!rb);
        n_din += int'(we_n && !we_q && !cle && !ale);
        we_q = we_n;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 rv = o_rdata;
    endtask
    // Poll the busy flag under a bound
    task automatic wait_idle();
        int i;
        for (i = 0; i < 3000; i++)
        begin
            rd(`NPES_REG_STATUS);
            if (rv[2] === 1'b0)
                break;
        end
        if (i == 3000)
            chk(32'h1, 32'h0);
    endtask
    // Start an operation and wait for idle
    task automatic op(input logic [2:0] code);
        wr(`NPES_REG_CTRL, {29'h0, code});
        wait_idle();
    endtask
    task automatic t_protect();
        b0 = n_busy;
        wr(`NPES_REG_CFG, 32'h0);
        op(`NPES_OP_PROG_START);
        chk({31'h0, rv[6]}, 32'h1);
        chk(n_busy - b0, 32'h0);
    endtask
    task automatic t_program();
        wr(`NPES_REG_CFG, 32'h1);
        wr(`NPES_REG_ROW, 32'h40);
        wr(`NPES_REG_COL, 32'h0);
        op(`NPES_OP_PROG_START);
        d0 = n_din;
        for (int k = 0; k < 3; k++)
        begin
            wr(`NPES_REG_DATA, 32'h5a + k);
            wait_idle();
        end
        wr(`NPES_REG_COL, 32'h10);
        op(`NPES_OP_RAND_IN);
        wr(`NPES_REG_DATA, 32'ha5);
        wait_idle();
        b0 = n_busy;
        op(`NPES_OP_CONFIRM);
        chk(n_din - d0, 32'h4);
        chk({31'h0, n_busy > b0}, 32'h1);
        chk({30'h0, rv[6:5]}, 32'h1);
        rd(`NPES_REG_FLASH_SR);
        chk(rv & 32'hff, 32'he0);
    endtask
    task automatic t_erase_copy();
        wr(`NPES_REG_ROW, 32'h7f);
        op(`NPES_OP_ERASE);
        rd(`NPES_REG_FLASH_SR);
        chk(rv & 32'hff, 32'he0);
        b0 = n_busy;
        wr(`NPES_REG_ROW, 32'h40);
        op(`NPES_OP_CB_READ);
        chk({31'h0, n_busy > b0}, 32'h1);
        rd(`NPES_REG_RDATA);
        wait_idle();
        rd(`NPES_REG_RDATA);
        chk(rv & 32'hff, 32'he0);
        wr(`NPES_REG_ROW, 32'h80);
        op(`NPES_OP_CB_PROG);
        rd(`NPES_REG_FLASH_SR);
        chk(rv & 32'hff, 32'he0);
        b0 = n_busy;
        op(`NPES_OP_RESET);
        chk({31'h0, n_busy > b0}, 32'h1);
        chk({31'h0, rv[7]}, 32'h0);
    endtask
    task automatic end_sim();
        $display("Compared %0d, errors %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (16) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        t_protect();
        t_program();
        t_erase_copy();
        end_sim();
    end
    // Watchdog
    initial
    begin
        #500000;
        fail_count++;
        end_sim();
    end
endmodule
bind npes_host npes_host_monitor u_mon (.*);
`default_nettype wire
